//--- logic/gcsc_serial_control.sv
// serial control port: shifter on the serial clock, control latch on clk_in
`timescale 1ns/1ns
module gcsc_serial_control
  import gcsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic sclk_in,
  input wire logic load_enable_n_in,
  input wire logic serial_word_in,
  input wire logic transmit_enable_in,
  input wire logic sleep_n_in,
  output logic [GCSC_LEVEL_W-1:0] current_level_out,
  output logic [3:0] current_select_out,
  output logic [GCSC_GAIN_W-1:0] gain_code_out,
  output logic signed [6:0] gain_db_out,
  output logic [3:0] coarse_attenuator_out,
  output logic [2:0] vernier_step_out,
  output logic gain_valid_out,
  output logic word_loaded_out,
  output logic tx_active_out,
  output logic sleep_mode_out
);

  // link domain: master-slave shifter, no reset (the link has none)
  logic [GCSC_WORD_W-1:0] master_reg;
  logic [GCSC_WORD_W-1:0] slave_reg;
  logic [GCSC_WORD_W-1:0] shift_next;

  // shifting chains through the slave so the first bit ends up in bit 7
  assign shift_next = {slave_reg[GCSC_WORD_W-2:0], serial_word_in}; // [RULE5] [RULE1]

  always_ff @(posedge sclk_in) begin
    if (!load_enable_n_in) begin // [RULE4] [RULE13]
      master_reg <= shift_next; // [RULE5]
    end
  end

  always_ff @(negedge sclk_in) begin
    slave_reg <= master_reg; // [RULE12]
  end

  shift_capture_a: assert property (@(posedge sclk_in) // [RULE5]
    !load_enable_n_in |=> master_reg[0] == $past(serial_word_in))
    else $error("serial bit not captured on rising clock");

  shift_idle_a: assert property (@(posedge sclk_in) // [RULE13]
    load_enable_n_in |=> master_reg == $past(master_reg))
    else $error("shifter moved while load enable high");

  // shifter has no reset, so unshifted bits stay unknown; compare them exactly
  slave_move_a: assert property (@(posedge sclk_in) // [RULE12]
    1'b1 |=> slave_reg === master_reg)
    else $error("slave stage missed falling clock transfer");

  // each new bit enters below the bits already held by the slave stage
  shift_chain_a: assert property (@(posedge sclk_in) // [RULE5]
    !load_enable_n_in |=> master_reg[7:1] === $past(slave_reg[6:0]))
    else $error("shift chain lost earlier bits");

  // system domain: synchronise the pins, then act on load enable rising
  logic [GCSC_SYNC_STAGES-1:0] le_sync_reg;
  logic le_prev_reg;
  logic [GCSC_SYNC_STAGES-1:0] tx_sync_reg;
  logic [GCSC_SYNC_STAGES-1:0] sleep_sync_reg;
  logic [GCSC_WORD_W-1:0] word_reg;
  logic [GCSC_WORD_W-1:0] word_next;
  logic loaded_reg;
  logic le_rise;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      le_sync_reg <= '1;
      tx_sync_reg <= '0;
      sleep_sync_reg <= '0;
      le_prev_reg <= 1'b1;
    end else begin
      le_sync_reg <= {le_sync_reg[0], load_enable_n_in};
      tx_sync_reg <= {tx_sync_reg[0], transmit_enable_in};
      sleep_sync_reg <= {sleep_sync_reg[0], sleep_n_in};
      le_prev_reg <= le_sync_reg[1];
    end
  end

  // the shifter is frozen while load enable is high, so reading it here
  // after synchronised rising edge is a quasi-static word crossing
  assign le_rise = le_sync_reg[1] && !le_prev_reg;
  assign word_next = le_rise ? slave_reg : word_reg; // [RULE6] [RULE13]

  // cleared only so the outputs are never unknown; loaded flag says undefined
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      word_reg <= GCSC_WORD_RST; // [RULE10]
      loaded_reg <= 1'b0; // [RULE10]
    end else begin
      word_reg <= word_next; // [RULE6]
      loaded_reg <= loaded_reg || le_rise;
    end
  end

  latch_update_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE6]
    le_rise |=> word_reg == $past(slave_reg) && word_loaded_out)
    else $error("control latch not updated on load enable rise");

  latch_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE13]
    !le_rise |=> word_reg == $past(word_reg))
    else $error("control latch changed without load enable rise");

  // field decode
  logic [5:0] code_m1;
  assign current_level_out = word_reg[GCSC_LEVEL_MSB:GCSC_LEVEL_LSB]; // [RULE1]
  assign gain_code_out = word_reg[GCSC_GAIN_MSB:0]; // [RULE1]
  assign gain_valid_out = loaded_reg && (gain_code_out >= GCSC_GAIN_MIN)
    && (gain_code_out <= GCSC_GAIN_MAX); // [RULE2]
  assign gain_db_out = $signed({1'b0, gain_code_out}) - $signed(GCSC_DB_OFFSET); // [RULE2]
  // 6 dB coarse stage plus 1 dB vernier, counted up from minimum gain
  assign code_m1 = gain_code_out - GCSC_GAIN_MIN;
  assign coarse_attenuator_out = 4'(code_m1 / GCSC_COARSE_STEP); // [RULE2]
  assign vernier_step_out = 3'(code_m1 % GCSC_COARSE_STEP); // [RULE2]
  assign current_select_out = 4'h1 << current_level_out; // [RULE3]
  assign word_loaded_out = loaded_reg;

  field_split_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE1]
    le_rise |=> current_level_out == $past(slave_reg[7:6])
    && gain_code_out == $past(slave_reg[5:0]))
    else $error("word fields split wrongly");

  gain_step_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE2]
    gain_valid_out |-> gain_db_out == $signed({1'b0, gain_code_out}) - 7'sd28)
    else $error("gain in dB not code minus 28");

  current_sel_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE3]
    (current_level_out == 2'h3 |-> current_select_out == 4'h8)
    and (current_level_out == 2'h0 |-> current_select_out == 4'h1))
    else $error("current setting select wrong");

  // asynchronous power controls; the latch is untouched by either
  assign tx_active_out = tx_sync_reg[1] && sleep_sync_reg[1]; // [RULE7]
  assign sleep_mode_out = !sleep_sync_reg[1]; // [RULE8]

  tx_follow_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE7]
    $past(rstn_in, 2) && $past(rstn_in) |->
    tx_active_out == ($past(transmit_enable_in, 2) && $past(sleep_n_in, 2)))
    else $error("transmit state does not follow enable");

  sleep_follow_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE8]
    $past(rstn_in, 2) && $past(rstn_in) |-> sleep_mode_out == !$past(sleep_n_in, 2))
    else $error("sleep state does not follow input");

  tx_keep_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE7]
    $changed(tx_active_out) && !le_rise |=> $stable(word_reg))
    else $error("settings lost on transmit change");

  // sleep toggles must not disturb the latched word either
  sleep_keep_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE8]
    $changed(sleep_mode_out) && !le_rise |=> $stable(word_reg))
    else $error("settings lost on sleep change");

  sleep_gates_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE8]
    sleep_mode_out |-> !tx_active_out)
    else $error("transmit active while asleep");

  sleep_off_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE8]
    $past(rstn_in, 2) && $past(rstn_in) && !$past(sleep_n_in, 2)
    |-> sleep_mode_out && !tx_active_out)
    else $error("sleep input low did not power down");

  tx_on_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE7]
    $past(rstn_in, 2) && $past(rstn_in) && $past(transmit_enable_in, 2)
    && $past(sleep_n_in, 2) |-> tx_active_out)
    else $error("transmit not enabled when allowed");

  // reset behaviour: outputs known, gain marked undefined, no false edge
  reset_latch_a: assert property (@(posedge clk_in) // [RULE10]
    !rstn_in |=> word_reg == GCSC_WORD_RST && !word_loaded_out)
    else $error("latch not cleared by reset");

  reset_power_a: assert property (@(posedge clk_in) // [RULE7]
    !rstn_in |=> !tx_active_out && sleep_mode_out)
    else $error("power outputs wrong during reset");

  sync_idle_a: assert property (@(posedge clk_in) // [RULE4]
    !rstn_in |=> le_sync_reg == '1 && le_prev_reg)
    else $error("load enable sync not at idle level");

  // edge detector starts at the idle level, so release of reset is no load
  no_false_edge_a: assert property (@(posedge clk_in) // [RULE6]
    !rstn_in |=> !le_rise)
    else $error("false load edge after reset");

  rise_single_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE6]
    le_rise |=> !le_rise)
    else $error("load edge lasted more than one cycle");

  loaded_rise_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE6]
    $rose(word_loaded_out) |-> $past(le_rise))
    else $error("loaded flag rose without a load");

  loaded_keep_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE10]
    word_loaded_out |=> word_loaded_out)
    else $error("loaded flag dropped");

  unloaded_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE10]
    !word_loaded_out |-> !gain_valid_out)
    else $error("gain valid before any load");

  latch_static_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE13]
    !le_rise |=> $stable(current_level_out) && $stable(gain_code_out))
    else $error("applied fields moved without a load");

  // gain code range and its dB meaning
  valid_range_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE2]
    gain_valid_out |-> gain_code_out >= 6'h01 && gain_code_out <= 6'h3C)
    else $error("gain valid outside code range");

  valid_loaded_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE2]
    word_loaded_out && gain_code_out >= 6'h01 && gain_code_out <= 6'h3C
    |-> gain_valid_out)
    else $error("legal code not flagged valid");

  code_zero_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE2]
    gain_code_out == 6'h00 |-> !gain_valid_out)
    else $error("code zero flagged valid");

  code_high_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE2]
    gain_code_out > 6'h3C |-> !gain_valid_out)
    else $error("code above maximum flagged valid");

  db_range_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE2]
    gain_valid_out |-> gain_db_out >= -7'sd27 && gain_db_out <= 7'sd32)
    else $error("gain outside dB range");

  db_min_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE2]
    gain_code_out == 6'h01 |-> gain_db_out == -7'sd27)
    else $error("minimum code not at minimum gain");

  db_max_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE2]
    gain_code_out == 6'h3C |-> gain_db_out == 7'sd32)
    else $error("maximum code not at maximum gain");

  // split into coarse and vernier must rebuild the code exactly
  coarse_max_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE2]
    gain_valid_out |-> coarse_attenuator_out <= 4'h9)
    else $error("coarse step out of range");

  vernier_max_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE2]
    gain_valid_out |-> vernier_step_out <= 3'h5)
    else $error("vernier step out of range");

  gain_rebuild_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE2]
    gain_valid_out |-> ({2'h0, coarse_attenuator_out} * 6'h06)
    + {3'h0, vernier_step_out} + 6'h01 == gain_code_out)
    else $error("coarse and vernier do not rebuild code");

  // current level selects stay one-hot and ordered
  select_hot_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE3]
    1'b1 |-> $onehot(current_select_out))
    else $error("current select not one-hot");

  select_mid_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RULE3]
    (current_level_out == 2'h2 |-> current_select_out == 4'h4)
    and (current_level_out == 2'h1 |-> current_select_out == 4'h2))
    else $error("middle current settings wrong");

endmodule : gcsc_serial_control

//--- pkg/gcsc_pkg.sv
// constants for the gain and current serial control port
// Behaviour
// RULE1: eight-bit word, MSB first, current then gain
// RULE2: gain codes 01 to 3C, one dB steps
// RULE3: current bits pick one of four settings
// RULE4: falling load enable arms serial shifting
// RULE5: rising serial clock samples data into shifter
// RULE6: rising load enable transfers word to latch
// RULE7: transmit enable gates transmission, settings kept
// RULE8: active-low sleep input powers down amplifier
// RULE9: controller changes sleep only with transmit low
// RULE10: latch content undefined until first load
// RULE11: controller loads word before raising transmit enable
// RULE12: falling serial clock moves bit to slave
// RULE13: shifting ignored while high, latch held while low
// RULE14: controller sends eight clocks and valid codes; the bench model also sends gain codes 3D and 00
package gcsc_pkg;
  localparam int GCSC_WORD_W = 8;
  localparam int GCSC_GAIN_W = 6;
  localparam int GCSC_LEVEL_W = 2;
  localparam int GCSC_LEVEL_MSB = 7;
  localparam int GCSC_LEVEL_LSB = 6;
  localparam int GCSC_GAIN_MSB = 5;
  localparam logic [5:0] GCSC_GAIN_MIN = 6'h01;
  localparam logic [5:0] GCSC_GAIN_MAX = 6'h3C;
  localparam logic [6:0] GCSC_DB_OFFSET = 7'h1C;
  localparam logic [5:0] GCSC_COARSE_STEP = 6'h06;
  localparam logic [7:0] GCSC_WORD_RST = 8'h00;
  localparam int GCSC_SYNC_STAGES = 2;
endpackage : gcsc_pkg

//--- testbench/gain_current_serial_control_tb.sv
// self-checking bench for the serial control port
`timescale 1ns/1ns
module gain_current_serial_control_tb;
  import gcsc_pkg::*;
  typedef struct packed {logic [7:0] w; logic [6:0] db; logic [3:0] sel; logic ok;} gcsc_row_t;
  logic clk_in, rstn_in, sclk, len_n, sdat, tx, slp_n, gv, wl, txa, slm;
  logic [1:0] lvl;
  logic [3:0] sel, co;
  logic [5:0] gc;
  logic signed [6:0] db;
  logic [2:0] vs;
  int error_cnt = 0;
  int total_checks = 0;
  gcsc_row_t rows [5] = '{'{8'hFC, 7'h20, 4'h8, 1'b1}, '{8'h01, 7'h65, 4'h1, 1'b1},
    '{8'h9B, 7'h7F, 4'h4, 1'b1}, '{8'h3D, 7'h21, 4'h1, 1'b0}, '{8'h40, 7'h64, 4'h2, 1'b0}};
  logic [1:0] pw [4] = '{2'h0, 2'h1, 2'h3, 2'h1};
  gcsc_ctrl_model ctl_u (.sclk_out(sclk), .load_enable_n_out(len_n), .serial_word_in_out(sdat));
  gcsc_serial_control dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk),
    .load_enable_n_in(len_n), .serial_word_in(sdat), .transmit_enable_in(tx),
    .sleep_n_in(slp_n), .current_level_out(lvl), .current_select_out(sel),
    .gain_code_out(gc), .gain_db_out(db), .coarse_attenuator_out(co),
    .vernier_step_out(vs), .gain_valid_out(gv), .word_loaded_out(wl),
    .tx_active_out(txa), .sleep_mode_out(slm));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #1000000 error_cnt++;
    summarize();
  end
  initial begin
    rstn_in = 1'b0;
    tx = 1'b0; // held low until a word is loaded
    slp_n = 1'b1;
    repeat (16) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    @(posedge clk_in);
    #1 chk("loaded", {7'h00, wl}, 8'h00);
    chk("valid0", {7'h00, gv}, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      ctl_u.send(rows[i].w);
      repeat (6) @(posedge clk_in);
      #1 chk("level", {6'h00, lvl}, {6'h00, rows[i].w[7:6]});
      chk("code", {2'h0, gc}, {2'h0, rows[i].w[5:0]});
      chk("db", {1'b0, db}, {1'b0, rows[i].db});
      chk("select", {4'h0, sel}, {4'h0, rows[i].sel});
      chk("valid", {7'h00, gv}, {7'h00, rows[i].ok});
      chk("loaded", {7'h00, wl}, 8'h01);
      if (rows[i].ok) begin
        chk("coarse", {4'h0, co}, {2'h0, (rows[i].w[5:0] - 6'h01) / 6'h06});
        chk("vernier", {5'h00, vs}, {2'h0, (rows[i].w[5:0] - 6'h01) % 6'h06});
      end
      $display("row %0d done", i);
    end
    // sleep only moves while transmit is low
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      #1 tx = pw[k][1];
      slp_n = pw[k][0];
      repeat (4) @(posedge clk_in);
      #1 chk("tx", {7'h00, txa}, {7'h00, pw[k][1] & pw[k][0]});
      chk("sleep", {7'h00, slm}, {7'h00, ~pw[k][0]});
      chk("kept", {2'h0, gc}, 8'h00);
    end
    $display("power test done");
    summarize();
  end
endmodule : gain_current_serial_control_tb

//--- testbench/gcsc_ctrl_model.sv
// modem controller model driving the three serial control pins
`timescale 1ns/1ns
module gcsc_ctrl_model (
  output logic sclk_out,
  output logic load_enable_n_out,
  output logic serial_word_in_out
);
  initial begin
    sclk_out = 1'b0;
    load_enable_n_out = 1'b1;
    serial_word_in_out = 1'b0;
  end
  // clock stands still outside frames, 64 ns period inside
  task automatic send(input logic [7:0] w);
    load_enable_n_out = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      serial_word_in_out = w[i];
      #32 sclk_out = 1'b1;
      #32 sclk_out = 1'b0;
    end
    #32 load_enable_n_out = 1'b1;
    serial_word_in_out = ~w[0];
  endtask : send
endmodule : gcsc_ctrl_model
